// File: rtl/xmbw_regs.svh
// Constants for the external memory bus wait block
`ifndef XMBW_REGS_SVH
`define XMBW_REGS_SVH
// Bus width select levels
`define XMBW_WIDTH_8 1'b1
`define XMBW_WIDTH_16 1'b0
// Position of the wait-select bit in the processor mode byte
`define XMBW_WAIT_SEL_BIT 2
// Extra strobe-low cycles added by the software wait
`define XMBW_SW_WAITS 2'h1
// Extra strobe-low cycles every cycle gets, so the wait request clears the synchroniser
`define XMBW_BASE_HOLD 2'h1
`endif

// File: rtl/xmbw_pkg.sv
// Types for the external memory bus wait block
package xmbw_pkg;
  typedef enum logic [1:0] {
    XMBW_IDLE = 2'b00,
    XMBW_ADDR = 2'b01,
    XMBW_STRB = 2'b10,
    XMBW_DONE = 2'b11
  } xmbw_state_t;
  typedef enum logic [1:0] {
    XMBW_MIN = 2'b00,
    XMBW_MED_A = 2'b01,
    XMBW_MED_B = 2'b10,
    XMBW_MAX = 2'b11
  } xmbw_model_t;
endpackage

// File: rtl/xmbw_bus.sv
// External memory bus sequencer with software and hardware wait insertion
`timescale 1ns/1ps
`default_nettype none
`include "xmbw_regs.svh"
module xmbw_bus #(
  parameter int ADDR_W = 24
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Configuration pins
  input wire logic width_sel_i,
  input wire logic [7:0] mode_reg_i,
  input wire logic wait_req_n_i,
  // Core request side
  input wire logic req_i,
  input wire logic req_internal_i,
  input wire logic req_write_i,
  input wire logic req_byte_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [15:0] req_wdata_i,
  output logic done_o,
  output logic [15:0] rdata_o,
  output logic bus16_o,
  output logic [1:0] model_o,
  // External bus pins
  output logic strobe_n_o,
  output logic ale_o,
  output logic rw_o,
  output logic high_byte_enable_out_n_o,
  output logic [7:0] addr_lo_o,
  output logic [15:0] data_o,
  output logic [15:0] data_oe_n_o,
  input wire logic [15:0] data_i,
  output logic clk_out_o
);
  // Address byte split below assumes a 24-bit address
  if (ADDR_W != 24) begin : g_addr_w_check
    $error("ADDR_W must be 24");
  end

  // Two-flop synchronisers for pin inputs, plus the registered width
  logic [1:0] wr_sync_reg, wr_sync_next;
  logic [1:0] ws_sync_reg, ws_sync_next;
  logic bus16_reg, bus16_next;
  always_comb begin
    // Sampled every system clock, so every fall of clk_out is covered
    wr_sync_next = {wr_sync_reg[0], wait_req_n_i};
    ws_sync_next = {ws_sync_reg[0], width_sel_i};
    bus16_next = (ws_sync_reg[1] == `XMBW_WIDTH_16);
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_sync_reg <= 2'h3;
      ws_sync_reg <= 2'h3;
      bus16_reg <= 1'b0;
    end else begin
      wr_sync_reg <= wr_sync_next;
      ws_sync_reg <= ws_sync_next;
      bus16_reg <= bus16_next;
    end
  end
  logic wait_req_n_s;
  logic bus8_s;
  assign wait_req_n_s = wr_sync_reg[1];
  assign bus8_s = (ws_sync_reg[1] == `XMBW_WIDTH_8);

  // Model from width and whether upper address byte is in use
  function automatic xmbw_pkg::xmbw_model_t model_of(input logic b8, input logic [7:0] hi);
    if (b8) begin
      model_of = (hi == 8'h00) ? xmbw_pkg::XMBW_MIN : xmbw_pkg::XMBW_MED_A;
    end else begin
      model_of = (hi == 8'h00) ? xmbw_pkg::XMBW_MED_B : xmbw_pkg::XMBW_MAX;
    end
  endfunction

  // Bus cycle sequencer state
  xmbw_pkg::xmbw_state_t st_reg, st_next;
  xmbw_pkg::xmbw_model_t mdl_reg, mdl_next;
  logic [1:0] sw_cnt_reg, sw_cnt_next;
  logic phase_reg, phase_next;
  logic strobe_n_reg, strobe_n_next;
  logic ale_reg, ale_next;
  logic rw_reg, rw_next;
  logic hbe_n_reg, hbe_n_next;
  logic [7:0] alo_reg, alo_next;
  logic [15:0] dout_reg, dout_next;
  logic [15:0] doe_n_reg, doe_n_next;
  logic [15:0] rdata_reg, rdata_next;
  logic done_reg, done_next;
  logic int_reg, int_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [15:0] wdata_reg, wdata_next;

  // Next-state logic; clk_out runs at half the system clock
  always_comb begin
    st_next = st_reg;
    mdl_next = mdl_reg;
    sw_cnt_next = sw_cnt_reg;
    phase_next = ~phase_reg;
    strobe_n_next = strobe_n_reg;
    ale_next = 1'b0;
    rw_next = rw_reg;
    hbe_n_next = hbe_n_reg;
    alo_next = alo_reg;
    dout_next = dout_reg;
    doe_n_next = doe_n_reg;
    rdata_next = rdata_reg;
    done_next = 1'b0;
    int_next = int_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    unique case (st_reg)
      xmbw_pkg::XMBW_IDLE: begin
        if (req_i) begin
          addr_next = req_addr_i;
          wdata_next = req_wdata_i;
          int_next = req_internal_i;
          mdl_next = model_of(bus8_s, req_addr_i[23:16]);
          rw_next = ~req_write_i;
          hbe_n_next = bus8_s | req_byte_i & ~req_addr_i[0];
          alo_next = req_addr_i[7:0];
          // Multiplexed address bytes go out on the data lines
          dout_next = {req_addr_i[23:16], req_addr_i[15:8]};
          doe_n_next = 16'h0000;
          // Minimum model latches nothing, the ALE pulse is harmless to it
          ale_next = 1'b1;
          st_next = xmbw_pkg::XMBW_ADDR;
        end
      end
      xmbw_pkg::XMBW_ADDR: begin
        strobe_n_next = 1'b0;
        dout_next = wdata_reg;
        doe_n_next = rw_reg ? 16'hFFFF : (bus8_s ? 16'hFF00 : 16'h0000);
        // Base hold lets an address-phase wait request reach the sampler in time
        // Software wait adds one more cycle; internal area skips it
        sw_cnt_next = (!mode_reg_i[`XMBW_WAIT_SEL_BIT] && !int_reg) ? (`XMBW_BASE_HOLD + `XMBW_SW_WAITS) :
          `XMBW_BASE_HOLD;
        st_next = xmbw_pkg::XMBW_STRB;
      end
      xmbw_pkg::XMBW_STRB: begin
        // Request checked on every access, internal ones included
        if (sw_cnt_reg != 2'h0) begin
          sw_cnt_next = sw_cnt_reg - 2'h1;
        end else if (!wait_req_n_s) begin
          st_next = xmbw_pkg::XMBW_STRB;
        end else begin
          rdata_next = data_i;
          strobe_n_next = 1'b1;
          st_next = xmbw_pkg::XMBW_DONE;
        end
      end
      xmbw_pkg::XMBW_DONE: begin
        doe_n_next = 16'hFFFF;
        done_next = 1'b1;
        st_next = xmbw_pkg::XMBW_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_reg <= xmbw_pkg::XMBW_IDLE;
      mdl_reg <= xmbw_pkg::XMBW_MIN;
      sw_cnt_reg <= 2'h0;
      phase_reg <= 1'b1;
      strobe_n_reg <= 1'b1;
      ale_reg <= 1'b0;
      rw_reg <= 1'b1;
      hbe_n_reg <= 1'b1;
      alo_reg <= 8'h00;
      dout_reg <= 16'h0000;
      doe_n_reg <= 16'hFFFF;
      rdata_reg <= 16'h0000;
      done_reg <= 1'b0;
      int_reg <= 1'b0;
      addr_reg <= '0;
      wdata_reg <= 16'h0000;
    end else begin
      st_reg <= st_next;
      mdl_reg <= mdl_next;
      sw_cnt_reg <= sw_cnt_next;
      phase_reg <= phase_next;
      strobe_n_reg <= strobe_n_next;
      ale_reg <= ale_next;
      rw_reg <= rw_next;
      hbe_n_reg <= hbe_n_next;
      alo_reg <= alo_next;
      dout_reg <= dout_next;
      doe_n_reg <= doe_n_next;
      rdata_reg <= rdata_next;
      done_reg <= done_next;
      int_reg <= int_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
    end
  end

  // Outputs straight from flops
  assign strobe_n_o = strobe_n_reg;
  assign ale_o = ale_reg;
  assign rw_o = rw_reg;
  assign high_byte_enable_out_n_o = hbe_n_reg;
  assign addr_lo_o = alo_reg;
  assign data_o = dout_reg;
  assign data_oe_n_o = doe_n_reg;
  assign rdata_o = rdata_reg;
  assign done_o = done_reg;
  assign clk_out_o = phase_reg;
  assign model_o = mdl_reg;
  assign bus16_o = bus16_reg;

  // Strobe stays low while request is seen low at the sample point
  sequence s_frozen;
    st_reg == xmbw_pkg::XMBW_STRB && sw_cnt_reg == 2'h0 && !wait_req_n_s;
  endsequence
  a_wait_holds: assert property (@(posedge clk_i) disable iff (srst_i)
    s_frozen |=> !strobe_n_o && st_reg == xmbw_pkg::XMBW_STRB)
    else $error("strobe released during wait request");
  // A frozen cycle keeps its address and data still
  a_freeze_stable: assert property (@(posedge clk_i) disable iff (srst_i)
    s_frozen |=> $stable(data_o) && $stable(addr_lo_o) && $stable(high_byte_enable_out_n_o))
    else $error("bus lines moved during wait");
  // Software wait gives a third strobe-low cycle
  sequence s_sw_start;
    st_reg == xmbw_pkg::XMBW_ADDR && !mode_reg_i[`XMBW_WAIT_SEL_BIT] && !int_reg;
  endsequence
  a_soft_wait: assert property (@(posedge clk_i) disable iff (srst_i)
    s_sw_start |=> !strobe_n_o [*3])
    else $error("software wait missing");
  // Width select sets the high byte enable
  a_width_bus: assert property (@(posedge clk_i) disable iff (srst_i)
    (st_reg == xmbw_pkg::XMBW_ADDR && !bus16_o) |-> high_byte_enable_out_n_o)
    else $error("high byte enabled on 8-bit bus");
  // Multiplexed address bytes sit on the data lines during the latch pulse
  a_addr_mux: assert property (@(posedge clk_i) disable iff (srst_i)
    ale_o |-> data_oe_n_o == 16'h0000 && data_o == {addr_reg[23:16], addr_reg[15:8]})
    else $error("address bytes missing on data lines");
  // Completion is a single-cycle pulse
  a_done_pulse: assert property (@(posedge clk_i) disable iff (srst_i)
    done_o |=> !done_o)
    else $error("done held longer than one cycle");
endmodule // xmbw_bus
`default_nettype wire

// File: dv/xmbw_ext_mem.sv
// Behavioural external memory with chip-select qualified wait requests
`timescale 1ns/1ps
`default_nettype none
module xmbw_ext_mem (
  // Clock
  input wire logic clk_i,
  // Bus from the device; no address is latched on ALE, only the wait count when selected
  input wire logic strobe_n_i,
  input wire logic ale_i,
  input wire logic rw_i,
  input wire logic bus16_i,
  input wire logic hbe_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] dev_d_i,
  input wire logic [15:0] dev_oe_n_i,
  // Test controls
  input wire logic cs_i,
  input wire logic [3:0] waits_i,
  // Back to the device
  output logic [15:0] d_o,
  output logic wait_n_o
);
  logic [7:0] mem [256];
  logic [15:0] pat = 16'h0000;
  logic [3:0] cnt = 4'h0;
  logic [15:0] rd;
  logic [7:0] ev;
  assign ev = bus16_i ? {addr_i[7:1], 1'b0} : addr_i;
  // Off-strobe the lines wander, so stale data never looks valid
  assign rd = (!strobe_n_i && rw_i) ? {bus16_i ? mem[ev | 8'h01] : pat[15:8], mem[ev]} : pat;
  assign d_o = (dev_oe_n_i & rd) | (~dev_oe_n_i & dev_d_i);
  // Chip select is decoded in the address phase, early enough for the device's sampler
  assign wait_n_o = !(ale_i && cs_i) && (cnt == 4'h0);
  // Waits only for selected cycles; counts through freezes
  always_ff @(posedge clk_i) begin
    pat <= ~pat;
    if (ale_i && cs_i) cnt <= waits_i;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    if (!strobe_n_i && !rw_i) begin
      if (!bus16_i || !addr_i[0]) mem[ev] <= dev_d_i[7:0];
      if (bus16_i && !hbe_n_i) mem[ev | 8'h01] <= dev_d_i[15:8];
    end
  end
endmodule // xmbw_ext_mem
`default_nettype wire

// File: dv/xmbw_tb.sv
// Self-checking bench for the external bus sequencer
`timescale 1ns/1ps
`default_nettype none
`include "xmbw_regs.svh"
module tb;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic width_sel_i = `XMBW_WIDTH_16;
  logic [7:0] mode_reg_i = 8'hFF;
  logic req_i = 1'b0, req_internal_i = 1'b0, req_write_i = 1'b0, req_byte_i = 1'b0;
  logic [23:0] req_addr_i = 24'h000000;
  logic [15:0] req_wdata_i = 16'h0000;
  logic cs = 1'b0;
  logic [3:0] waits = 4'h0;
  logic done_o, bus16_o, strobe_n_o, ale_o, rw_o, hbe_n, clk_out_o, wait_n;
  logic [1:0] model_o;
  logic [7:0] addr_lo_o;
  logic [15:0] rdata_o, data_o, data_oe_n_o, data_i;
  int n_errors = 0;
  int checks_done = 0;
  int lat;
  xmbw_bus dut_u (.clk_i(clk_i), .srst_i(srst_i), .width_sel_i(width_sel_i), .mode_reg_i(mode_reg_i),
    .wait_req_n_i(wait_n), .req_i(req_i), .req_internal_i(req_internal_i), .req_write_i(req_write_i),
    .req_byte_i(req_byte_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .done_o(done_o),
    .rdata_o(rdata_o), .bus16_o(bus16_o), .model_o(model_o), .strobe_n_o(strobe_n_o), .ale_o(ale_o),
    .rw_o(rw_o), .high_byte_enable_out_n_o(hbe_n), .addr_lo_o(addr_lo_o), .data_o(data_o),
    .data_oe_n_o(data_oe_n_o), .data_i(data_i), .clk_out_o(clk_out_o));
  xmbw_ext_mem mem_u (.clk_i(clk_i), .strobe_n_i(strobe_n_o), .ale_i(ale_o), .rw_i(rw_o), .bus16_i(bus16_o),
    .hbe_n_i(hbe_n), .addr_i(addr_lo_o), .dev_d_i(data_o), .dev_oe_n_i(data_oe_n_o), .cs_i(cs),
    .waits_i(waits), .d_o(data_i), .wait_n_o(wait_n));
  // Free-running system clock
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One bus cycle; lat counts edges from take to done
  task automatic access(input logic intl, input logic wr, input logic byt, input logic [23:0] a,
                        input logic [15:0] wd);
    @(posedge clk_i);
    req_i <= 1'b1;
    req_internal_i <= intl;
    req_write_i <= wr;
    req_byte_i <= byt;
    req_addr_i <= a;
    req_wdata_i <= wd;
    @(posedge clk_i);
    req_i <= 1'b0;
    #1;
    lat = 0;
    while (done_o !== 1'b1 && lat < 60) begin
      @(posedge clk_i);
      #1;
      lat++;
    end
  endtask
  task automatic report_and_stop;
    $display("Errors %0d of %0d checks", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard at 3000 cycles, well beyond the hundred or so cycles used
  initial begin
    #(100 * 3000);
    n_errors++;
    report_and_stop();
  end
  // Main sequence; synced pins get extra settling edges
  initial begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    access(1'b0, 1'b1, 1'b0, 24'h000010, 16'hA5C3);
    check("lat", 24'(lat), 24'd4);
    check("bus16", bus16_o, 1'b1);
    check("model", model_o, xmbw_pkg::XMBW_MED_B);
    check("hbe_n", hbe_n, 1'b0);
    access(1'b0, 1'b0, 1'b0, 24'h000010, 16'h0000);
    check("rdata", rdata_o, 16'hA5C3);
    @(posedge clk_i);
    mode_reg_i <= 8'hFB;
    access(1'b0, 1'b0, 1'b0, 24'h120010, 16'h0000);
    check("lat", 24'(lat), 24'd5);
    check("model", model_o, xmbw_pkg::XMBW_MAX);
    check("rdata", rdata_o, 16'hA5C3);
    access(1'b1, 1'b0, 1'b0, 24'h000010, 16'h0000);
    check("lat", 24'(lat), 24'd4);
    @(posedge clk_i);
    mode_reg_i <= 8'hFF;
    waits <= 4'h6;
    cs <= 1'b1;
    access(1'b0, 1'b0, 1'b0, 24'h000010, 16'h0000);
    check("stretch", lat > 5 && lat < 60, 1'b1);
    check("rdata", rdata_o, 16'hA5C3);
    @(posedge clk_i);
    cs <= 1'b0;
    access(1'b0, 1'b0, 1'b0, 24'h000010, 16'h0000);
    check("lat", 24'(lat), 24'd4);
    @(posedge clk_i);
    cs <= 1'b1;
    access(1'b1, 1'b0, 1'b0, 24'h000010, 16'h0000);
    check("stretch", lat > 5 && lat < 60, 1'b1);
    @(posedge clk_i);
    waits <= 4'h0;
    cs <= 1'b0;
    width_sel_i <= `XMBW_WIDTH_8;
    repeat (3) @(posedge clk_i);
    access(1'b0, 1'b1, 1'b1, 24'h000021, 16'h005A);
    check("lat", 24'(lat), 24'd4);
    check("bus16", bus16_o, 1'b0);
    check("hbe_n", hbe_n, 1'b1);
    check("addr_lo", addr_lo_o, 8'h21);
    check("model", model_o, xmbw_pkg::XMBW_MIN);
    access(1'b0, 1'b0, 1'b1, 24'h340021, 16'h0000);
    check("model", model_o, xmbw_pkg::XMBW_MED_A);
    check("rbyte", rdata_o[7:0], 8'h5A);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
